/* cc_exec_regs.svh */
// Purpose: offsets, field positions, reset values and opcodes of the exec block
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes:   definitions only
`ifndef CC_EXEC_REGS_SVH
`define CC_EXEC_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CC_DATA_W        8
`define CC_PC_W          13
`define CC_K_W           11
`define CC_F_W           7
`define CC_OP_W          4
`define CC_SP_W          3
`define CC_ADDR_W        8
`define CC_PRESC_W       8
`define CC_FILE_DEPTH    128

// ****************************************************************
// register offsets
// ****************************************************************
`define CC_REG_CMD       8'h00
`define CC_REG_WORK      8'h04
`define CC_REG_STATUS    8'h08
`define CC_REG_PC        8'h0c
`define CC_REG_PCLATCH   8'h10
`define CC_REG_STACKTOP  8'h14
`define CC_REG_WATCHDOG  8'h18
`define CC_REG_FADDR     8'h1c
`define CC_REG_FDATA     8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define CC_CMD_OP_LSB    0
`define CC_CMD_D_BIT     4
`define CC_CMD_F_LSB     8
`define CC_CMD_K_LSB     16
`define CC_CMD_BUSY_BIT  0
`define CC_ST_Z_BIT      2
`define CC_ST_PDF_BIT    3
`define CC_ST_TOF_BIT    4
`define CC_WD_CNT_LSB    0
`define CC_WD_PRESC_LSB  8
`define CC_LATCH_LO_BIT  3
`define CC_LATCH_W       5

// ****************************************************************
// reset values
// ****************************************************************
`define CC_RST_TOF       1'b1
`define CC_RST_PDF       1'b1
`define CC_RST_Z         1'b0

// ****************************************************************
// opcodes of the command register
// ****************************************************************
`define CC_OP_NONE       4'h0
`define CC_OP_WDCLR      4'h1
`define CC_OP_CALL       4'h2
`define CC_OP_COMPL      4'h3
`define CC_OP_FCLR       4'h4
`define CC_OP_DEC        4'h5
`define CC_OP_WCLR       4'h6
`define CC_OP_DECSKIP    4'h7

`endif

/* cc_pkg.sv */
// Purpose: shared types of the exec block
// Assumes: cc_exec_regs.svh macros
// Notes:   state codes are one-hot
`include "cc_exec_regs.svh"
package cc_pkg;

    typedef enum logic [2:0] {
        st_idle   = 3'h1,
        st_exec   = 3'h2,
        st_second = 3'h4
    } cc_state_e;

    typedef enum logic [`CC_OP_W-1:0] {
        no_operation           = `CC_OP_NONE,
        watchdog_clear_op      = `CC_OP_WDCLR,
        call_op                = `CC_OP_CALL,
        complement_file_op     = `CC_OP_COMPL,
        file_clear_op          = `CC_OP_FCLR,
        decrement_file_op      = `CC_OP_DEC,
        working_reg_clear_op   = `CC_OP_WCLR,
        decrement_skip_zero_op = `CC_OP_DECSKIP
    } cc_op_e;

    typedef logic [`CC_DATA_W-1:0] cc_byte_t;

endpackage

/* cc_alu.sv */
// Purpose: result, destination and zero flag of the data operations
// Assumes: file value and opcode stable during the exec cycle
// Notes:   purely combinational
`timescale 1ns/1ns
module cc_alu import cc_pkg::*; (
    input  wire cc_op_e   op,
    input  wire logic     dest_file,
    input  wire cc_byte_t fval,
    output cc_byte_t      result,
    output logic          zero,
    output logic          wr_work,
    output logic          wr_file,
    output logic          z_update
);
    always_comb begin
        result   = '0;
        wr_work  = 1'b0;
        wr_file  = 1'b0;
        z_update = 1'b0;
        case (op)
            complement_file_op: begin
                result   = ~fval;
                wr_work  = ~dest_file;
                wr_file  = dest_file;
                z_update = 1'b1;
            end
            file_clear_op: begin
                result   = '0;
                wr_file  = 1'b1;
                z_update = 1'b1;
            end
            decrement_file_op: begin
                result   = fval - cc_byte_t'(1);
                wr_work  = ~dest_file;
                wr_file  = dest_file;
                z_update = 1'b1;
            end
            working_reg_clear_op: begin
                result   = '0;
                wr_work  = 1'b1;
                z_update = 1'b1;
            end
            decrement_skip_zero_op: begin
                result   = fval - cc_byte_t'(1);
                wr_work  = ~dest_file;
                wr_file  = dest_file;
            end
            default: begin
                result   = '0;
            end
        endcase
        zero = (result == '0);
    end
endmodule // cc_alu

/* cc_file_regs.sv */
// Purpose: file registers held in flip-flops
// Assumes: one write port, two asynchronous read ports
// Notes:   cleared at reset
`timescale 1ns/1ns
`include "cc_exec_regs.svh"
module cc_file_regs import cc_pkg::*; (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 we,
    input  wire logic [`CC_F_W-1:0]   waddr,
    input  wire cc_byte_t             wdata,
    input  wire logic [`CC_F_W-1:0]   raddr_a,
    input  wire logic [`CC_F_W-1:0]   raddr_b,
    output cc_byte_t                  rdata_a,
    output cc_byte_t                  rdata_b
);
    typedef struct packed {
        logic [`CC_FILE_DEPTH-1:0][`CC_DATA_W-1:0] mem;
    } cc_file_s;

    cc_file_s cur;
    cc_file_s next_cur;

    always_comb begin
        next_cur = cur;
        if (we) begin
            next_cur.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_a = cur.mem[raddr_a];
    assign rdata_b = cur.mem[raddr_b];
endmodule // cc_file_regs

/* cc_exec.sv */
// Purpose: executes watchdog clear, call, complement, clear, decrement and skip ops
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes:   one instruction cycle is one clock
`timescale 1ns/1ns
`include "cc_exec_regs.svh"

// Operation
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets timeout and powerdown flags; no operands
// - call pushes program counter plus one onto the return stack
// - call loads its eleven-bit operand into program counter bits 10:0
// - call copies latch bits 4:3 into program counter bits 12:11
// - call takes two cycles and leaves all flags unchanged
// - file address 0..127; destination bit picks working or file register
// - complement writes inverted file value; updates only zero flag
// - file clear writes zero to the file register and sets zero
// - decrement writes file minus one to destination; updates only zero
// - working clear loads zero into working register and sets zero
// - decrement-skip writes file minus one, leaves flags alone
// - zero result of decrement-skip discards next instruction, two cycles
module cc_exec import cc_pkg::*; (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`CC_ADDR_W-1:0]  avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        cc_state_e                              state;
        cc_op_e                                 op;
        logic                                   dest;
        logic [`CC_F_W-1:0]                     faddr_op;
        logic [`CC_K_W-1:0]                     k;
        cc_byte_t                               work;
        logic                                   z;
        logic                                   tof;
        logic                                   pdf;
        logic [`CC_PC_W-1:0]                    pc;
        logic [`CC_LATCH_W-1:0]                 pclatch;
        logic [7:0][`CC_PC_W-1:0]               stack;
        logic [`CC_SP_W-1:0]                    sp;
        cc_byte_t                               wd_count;
        logic [`CC_PRESC_W-1:0]                 wd_presc;
        logic [`CC_F_W-1:0]                     faddr_bus;
        logic                                   rd_ack;
        logic [31:0]                            rdata;
    } cc_exec_s;

    cc_exec_s            cur;
    cc_exec_s            next_cur;
    cc_byte_t            file_a;
    cc_byte_t            file_b;
    cc_byte_t            alu_result;
    logic                alu_zero;
    logic                alu_wr_work;
    logic                alu_wr_file;
    logic                alu_z_update;
    logic                exec_now;
    logic                busy;
    logic                wr_ok;
    logic                f_we;
    logic [`CC_F_W-1:0]  f_waddr;
    cc_byte_t            f_wdata;
    logic [`CC_PC_W-1:0] pc_plus1;
    logic [`CC_PC_W-1:0] stack_top;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] read_mux(input cc_exec_s s, input logic [`CC_ADDR_W-1:0] a,
                                             input logic [`CC_PC_W-1:0] top, input cc_byte_t fd);
        logic [31:0] v;
        v = '0;
        case (a)
            `CC_REG_CMD:      v[`CC_CMD_BUSY_BIT] = (s.state != st_idle);
            `CC_REG_WORK:     v[`CC_DATA_W-1:0] = s.work;
            `CC_REG_STATUS: begin
                v[`CC_ST_Z_BIT]  = s.z;
                v[`CC_ST_PDF_BIT] = s.pdf;
                v[`CC_ST_TOF_BIT] = s.tof;
            end
            `CC_REG_PC:       v[`CC_PC_W-1:0] = s.pc;
            `CC_REG_PCLATCH:  v[`CC_LATCH_W-1:0] = s.pclatch;
            `CC_REG_STACKTOP: v[`CC_PC_W-1:0] = top;
            `CC_REG_WATCHDOG: begin
                v[`CC_WD_CNT_LSB +: `CC_DATA_W]    = s.wd_count;
                v[`CC_WD_PRESC_LSB +: `CC_PRESC_W] = s.wd_presc;
            end
            `CC_REG_FADDR:    v[`CC_F_W-1:0] = s.faddr_bus;
            `CC_REG_FDATA:    v[`CC_DATA_W-1:0] = fd;
            default:          v = '0;
        endcase
        return v;
    endfunction

    function automatic logic op_at(input cc_exec_s s, input cc_op_e o);
        return (s.state == st_exec) && (s.op == o);
    endfunction

    assign exec_now  = (cur.state == st_exec);
    assign busy      = (cur.state != st_idle);
    assign wr_ok     = avs_write && !busy;
    assign pc_plus1  = cur.pc + `CC_PC_W'(1);
    assign stack_top = cur.stack[cur.sp - `CC_SP_W'(1)];

    assign avs_waitrequest = (avs_read && !cur.rd_ack) || (avs_write && busy);
    assign avs_readdata    = cur.rdata;

    // ****************************************************************
    // submodules
    // ****************************************************************
    cc_alu u_alu (
        .op        (cur.op),
        .dest_file (cur.dest),
        .fval      (file_a),
        .result    (alu_result),
        .zero      (alu_zero),
        .wr_work   (alu_wr_work),
        .wr_file   (alu_wr_file),
        .z_update  (alu_z_update)
    );

    cc_file_regs u_file (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (f_we),
        .waddr   (f_waddr),
        .wdata   (f_wdata),
        .raddr_a (cur.faddr_op),
        .raddr_b (cur.faddr_bus),
        .rdata_a (file_a),
        .rdata_b (file_b)
    );

    // file write port: exec result, else bus data
    always_comb begin
        if (exec_now) begin
            f_we    = alu_wr_file;
            f_waddr = cur.faddr_op;
            f_wdata = alu_result;
        end else begin
            f_we    = wr_ok && (avs_address == `CC_REG_FDATA);
            f_waddr = cur.faddr_bus;
            f_wdata = avs_writedata[`CC_DATA_W-1:0];
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.rd_ack = 1'b0;
        if (avs_read && !cur.rd_ack) begin
            next_cur.rd_ack = 1'b1;
            next_cur.rdata  = read_mux(cur, avs_address, stack_top, file_b);
        end
        case (cur.state)
            st_idle: begin
                if (wr_ok) begin
                    case (avs_address)
                        `CC_REG_CMD: begin
                            next_cur.op       = cc_op_e'(avs_writedata[`CC_CMD_OP_LSB +: `CC_OP_W]);
                            next_cur.dest     = avs_writedata[`CC_CMD_D_BIT];
                            next_cur.faddr_op = avs_writedata[`CC_CMD_F_LSB +: `CC_F_W];
                            next_cur.k        = avs_writedata[`CC_CMD_K_LSB +: `CC_K_W];
                            next_cur.state    = st_exec;
                        end
                        `CC_REG_WORK:     next_cur.work = avs_writedata[`CC_DATA_W-1:0];
                        `CC_REG_STATUS: begin
                            next_cur.z   = avs_writedata[`CC_ST_Z_BIT];
                            next_cur.pdf = avs_writedata[`CC_ST_PDF_BIT];
                            next_cur.tof = avs_writedata[`CC_ST_TOF_BIT];
                        end
                        `CC_REG_PC:       next_cur.pc = avs_writedata[`CC_PC_W-1:0];
                        `CC_REG_PCLATCH:  next_cur.pclatch = avs_writedata[`CC_LATCH_W-1:0];
                        `CC_REG_WATCHDOG: begin
                            next_cur.wd_count = avs_writedata[`CC_WD_CNT_LSB +: `CC_DATA_W];
                            next_cur.wd_presc = avs_writedata[`CC_WD_PRESC_LSB +: `CC_PRESC_W];
                        end
                        `CC_REG_FADDR:    next_cur.faddr_bus = avs_writedata[`CC_F_W-1:0];
                        default:          next_cur.state = st_idle;
                    endcase
                end
            end
            st_exec: begin
                if (alu_wr_work) begin
                    next_cur.work = alu_result;
                end
                if (alu_z_update) begin
                    next_cur.z = alu_zero;
                end
                next_cur.pc    = pc_plus1;
                next_cur.state = st_idle;
                case (cur.op)
                    watchdog_clear_op: begin
                        next_cur.wd_count = '0;
                        next_cur.wd_presc = '0;
                        next_cur.tof      = 1'b1;
                        next_cur.pdf      = 1'b1;
                    end
                    call_op: begin
                        next_cur.stack[cur.sp] = pc_plus1;
                        next_cur.sp            = cur.sp + `CC_SP_W'(1);
                        next_cur.pc = {cur.pclatch[`CC_LATCH_LO_BIT +: 2],
                                       cur.k};
                        next_cur.state = st_second;
                    end
                    decrement_skip_zero_op: begin
                        if (alu_zero) begin
                            next_cur.state = st_second;
                        end
                    end
                    default: begin
                        next_cur.state = st_idle;
                    end
                endcase
            end
            st_second: begin
                if (cur.op != call_op) begin
                    next_cur.pc = pc_plus1;
                end
                next_cur.state = st_idle;
            end
            default: begin
                next_cur.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur       <= '0;
            cur.state <= st_idle;
            cur.op    <= no_operation;
            cur.tof   <= `CC_RST_TOF;
            cur.pdf   <= `CC_RST_PDF;
            cur.z     <= `CC_RST_Z;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_watchdog_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == watchdog_clear_op |=> cur.wd_count == '0 && cur.wd_presc == '0)
        else $error("watchdog not cleared");
    a_flags_set: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == watchdog_clear_op |=> cur.tof && cur.pdf)
        else $error("timeout or powerdown flag not set");
    a_call_push: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == call_op |=> stack_top == $past(cur.pc) + `CC_PC_W'(1))
        else $error("call pushed wrong return address");
    a_call_target: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == call_op |=> cur.pc[`CC_K_W-1:0] == $past(cur.k) ##1 cur.pc[`CC_K_W-1:0] == $past(cur.pc[`CC_K_W-1:0]))
        else $error("call target low bits wrong");
    a_call_upper: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == call_op |=> cur.pc[`CC_PC_W-1:`CC_K_W] == $past(cur.pclatch[`CC_LATCH_LO_BIT +: 2]))
        else $error("call upper bits wrong");
    a_call_two: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == call_op |=> cur.state == st_second && $stable(cur.z) ##1 cur.state == st_idle)
        else $error("call not two cycles or flag changed");
    a_compl_work: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == complement_file_op && !cur.dest |=> cur.work == ~$past(file_a))
        else $error("complement result wrong");
    a_clr_zero: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == file_clear_op |=> cur.z && file_a == '0)
        else $error("file clear failed");
    a_wclr_zero: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == working_reg_clear_op |=> cur.work == '0 && cur.z)
        else $error("working clear failed");
    a_skip_flags: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == decrement_skip_zero_op |=> $stable(cur.z) && $stable(cur.tof) && $stable(cur.pdf))
        else $error("decrement skip altered a flag");
    a_skip_taken: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op == decrement_skip_zero_op && alu_zero |=> cur.state == st_second ##1
        cur.pc == $past(cur.pc, 2) + `CC_PC_W'(2))
        else $error("skip did not discard next instruction");
    a_zero_track: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && alu_z_update |=> cur.z == ($past(alu_result) == '0))
        else $error("zero flag mismatch");
    a_single_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op != call_op && !(cur.op == decrement_skip_zero_op && alu_zero) |=> cur.state == st_idle)
        else $error("single cycle op took longer");

    a_call_sp: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, call_op) |=> cur.sp == $past(cur.sp) + `CC_SP_W'(1))
        else $error("call did not advance stack");
    a_stack_keep: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.op != call_op |=> $stable(cur.sp))
        else $error("stack moved without call");
    a_call_status: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, call_op) |=> $stable({cur.tof, cur.pdf}) ##1 $stable({cur.z, cur.tof, cur.pdf}))
        else $error("call altered a flag");
    a_dest_keep: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now && cur.dest && (cur.op == complement_file_op || cur.op == decrement_file_op
        || cur.op == decrement_skip_zero_op) |=> $stable(cur.work))
        else $error("file destination wrote working register");
    a_compl_file: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, complement_file_op) && cur.dest |=> file_a == ~$past(file_a))
        else $error("complement to file wrong");
    a_compl_status: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, complement_file_op) |=> $stable({cur.tof, cur.pdf}))
        else $error("complement altered a flag");
    a_fclr_keep: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, file_clear_op) |=> $stable({cur.work, cur.tof, cur.pdf}))
        else $error("file clear touched other state");
    a_dec_work: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, decrement_file_op) && !cur.dest |=> cur.work == $past(file_a) - cc_byte_t'(1))
        else $error("decrement to working wrong");
    a_dec_file: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, decrement_file_op) && cur.dest |=> file_a == $past(file_a) - cc_byte_t'(1))
        else $error("decrement to file wrong");
    a_wclr_status: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, working_reg_clear_op) |=> $stable({cur.tof, cur.pdf}))
        else $error("working clear altered a flag");
    a_skip_work: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, decrement_skip_zero_op) && !cur.dest |=> cur.work == $past(file_a) - cc_byte_t'(1))
        else $error("decrement skip to working wrong");
    a_skip_file: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, decrement_skip_zero_op) && cur.dest |=> file_a == $past(file_a) - cc_byte_t'(1))
        else $error("decrement skip to file wrong");
    a_skip_not: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, decrement_skip_zero_op) && file_a != cc_byte_t'(1) |=>
        cur.state == st_idle && cur.pc == $past(cur.pc) + `CC_PC_W'(1))
        else $error("skip taken on nonzero result");
    a_busy_bound: assert property (@(posedge clk) disable iff (!rst_n)
        exec_now |-> ##[1:2] cur.state == st_idle)
        else $error("operation exceeded two cycles");
    a_watchdog_keep: assert property (@(posedge clk) disable iff (!rst_n)
        op_at(cur, watchdog_clear_op) |=> $stable({cur.work, cur.z}))
        else $error("watchdog clear touched data state");
endmodule // cc_exec

/* tb.sv */
// Purpose: self-checking bench of cc_exec over its Avalon-MM register port
// Assumes: reads wait one cycle, writes stall while busy
// Notes:   bench model of w, status, pc, stack top, watchdog, file data
`timescale 1ns/1ns
`include "cc_exec_regs.svh"
module tb import cc_pkg::*;;
    logic        clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] seed = 32'h7042617a;
    int          fails;
    int          samples_checked;
    int          cycles;
    int          w, z, tof, pdf, pc, lat, top, wd, fv, f, d, k, op, res, n, exp_n, dummy;

    cc_exec dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
                 .avs_write(avs_write), .avs_writedata(avs_writedata),
                 .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] dt, output int nw);
        logic wq;
        nw = 0;
        avs_address   <= a;
        avs_writedata <= dt;
        avs_read      <= 1'b0;
        avs_write     <= 1'b1;
        do begin
            @(negedge clk);
            wq = avs_waitrequest;
            if (wq !== 1'b0) nw++;
            @(posedge clk);
        end while (wq !== 1'b0);
    endtask

    task chk_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic        wq;
        logic [31:0] q;
        avs_address <= a;
        avs_read    <= 1'b1;
        avs_write   <= 1'b0;
        do begin
            @(negedge clk);
            wq = avs_waitrequest;
            q  = avs_readdata;
            @(posedge clk);
        end while (wq !== 1'b0);
        samples_checked++;
        if ((q & mask) !== exp) begin
            fails++;
            $display("unexpected register at %0t: got %h expected %h", $time, q & mask, exp);
        end
    endtask

    task chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("unexpected wait count at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_reg(`CC_REG_STATUS, 32'h1c, 32'h18);
        chk_reg(`CC_REG_PC, 32'hffffffff, 32'h0);
        top = 0;
        for (int t = 0; t < 90; t++) begin
            op = t % 9;
            f = (t % 5 == 0) ? 127 : (t % 5 == 1) ? 0 : int'(rnd() % 128);
            fv = ((t / 9) % 3 == 0) ? 1 : ((t / 9) % 3 == 1) ? 255 : int'(rnd() % 256);
            d = int'(rnd() % 2);
            k = (t % 4 == 0) ? 2047 : int'(rnd() % 2048);
            w = int'(rnd() % 256);
            z = int'(rnd() % 2);
            tof = int'(rnd() % 2);
            pdf = int'(rnd() % 2);
            pc = int'(rnd() % 8192);
            lat = int'(rnd() % 32);
            wd = int'(rnd() % 65536);
            bus_wr(`CC_REG_WORK, w, dummy);
            bus_wr(`CC_REG_STATUS, (tof * 16) + (pdf * 8) + (z * 4), dummy);
            bus_wr(`CC_REG_PC, pc, dummy);
            bus_wr(`CC_REG_PCLATCH, lat, dummy);
            bus_wr(`CC_REG_WATCHDOG, wd, dummy);
            bus_wr(`CC_REG_STACKTOP, rnd(), dummy);
            bus_wr(`CC_REG_FADDR, f, dummy);
            bus_wr(`CC_REG_FDATA, fv, dummy);
            bus_wr(`CC_REG_CMD, op + (d * 16) + (f * 256) + (k * 65536), dummy);
            bus_wr(`CC_REG_FADDR, f, n);
            exp_n = 1;
            pc = (pc + 1) % 8192;
            case (op)
                1: begin wd = 0; tof = 1; pdf = 1; end
                2: begin top = pc; pc = ((lat / 8) % 4) * 2048 + k; exp_n = 2; end
                3, 5, 7: begin
                    res = (op == 3) ? 255 - fv : (fv + 255) % 256;
                    if (d == 1) fv = res;
                    else w = res;
                    if (op != 7) z = (res == 0) ? 1 : 0;
                    else if (res == 0) begin pc = (pc + 1) % 8192; exp_n = 2; end
                end
                4: begin fv = 0; z = 1; end
                6: begin w = 0; z = 1; end
                default: ;
            endcase
            chk_cnt(n, exp_n);
            chk_reg(`CC_REG_WORK, 32'hffffffff, w);
            chk_reg(`CC_REG_STATUS, 32'h1c, (tof * 16) + (pdf * 8) + (z * 4));
            chk_reg(`CC_REG_PC, 32'hffffffff, pc);
            chk_reg(`CC_REG_STACKTOP, 32'hffffffff, top);
            chk_reg(`CC_REG_WATCHDOG, 32'hffffffff, wd);
            chk_reg(`CC_REG_FDATA, 32'hffffffff, fv);
            chk_reg(8'h24, 32'hffffffff, 32'h0);
            chk_reg(`CC_REG_CMD, 32'h1, 32'h0);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        end_sim();
    end
endmodule // tb
